// ==== host_bus_model.sv ====
`timescale 1ns/100ps
// Host end of the register port; each task is entered just after a clock edge.
module host_bus_model
(
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [9:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // The spare upper byte always goes out as zero.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = {8'h00, d};
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
    endtask
    // Data is taken a full cycle after the strobe edge, once it has settled.
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        @(posedge clk_sys);
        #1 d = reg_rdata;
    endtask
endmodule

// ==== stage_flag_bank.sv ====
`timescale 1ns/100ps
// Eight sticky flags for one source kind; their enables gate only the pending level.
module stage_flag_bank
(
    input wire logic clk_sys,
    input wire logic rst,
    stage_flag_if.bank port
);
    import stage_irq_pkg::*;

    stage_vec_t flags_ff;
    stage_vec_t nxt_flags;
    logic pending_ff;
    logic nxt_pending;

    // ------------------------------------------------------------
    // Per-stage flag update
    // ------------------------------------------------------------
    // A new event or a still-exceeded limit wins over the read clear.
    genvar g;
    generate
        for (g = 0; g < STAGES; g++)
        begin : g_stage
            always_comb
            begin
                if (port.event_in[g] || port.cond_hold[g])
                    nxt_flags[g] = 1'b1;
                else if (port.read_clr)
                    nxt_flags[g] = 1'b0;
                else
                    nxt_flags[g] = flags_ff[g];
            end
        end
    endgenerate

    // A disabled stage can never raise the pending level.
    always_comb
    begin
        nxt_pending = |(nxt_flags & port.enable);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            flags_ff <= FLAG_RESET;
            pending_ff <= 1'b0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            pending_ff <= nxt_pending;
        end
    end

    assign port.flags = flags_ff;
    assign port.pending = pending_ff;
endmodule

// ==== stage_flag_if.sv ====
`timescale 1ns/100ps
// Carries one source kind between the top and a flag bank.
interface stage_flag_if;
    import stage_irq_pkg::*;
    stage_vec_t event_in;
    stage_vec_t cond_hold;
    logic read_clr;
    stage_vec_t enable;
    stage_vec_t flags;
    logic pending;
    modport bank
    (
        input event_in,
        input cond_hold,
        input read_clr,
        input enable,
        output flags,
        output pending
    );
    modport ctrl
    (
        output event_in,
        output cond_hold,
        output read_clr,
        output enable,
        input flags,
        input pending
    );
endinterface

// ==== stage_irq_ctrl.sv ====
`timescale 1ns/100ps
module stage_irq_ctrl
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [stage_irq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [stage_irq_pkg::DATA_W-1:0] reg_wdata,
    output logic [stage_irq_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [stage_irq_pkg::STAGES-1:0] lower_event,
    input wire logic [stage_irq_pkg::STAGES-1:0] lower_exceeded,
    input wire logic [stage_irq_pkg::STAGES-1:0] upper_event,
    input wire logic [stage_irq_pkg::STAGES-1:0] upper_exceeded,
    input wire logic [stage_irq_pkg::STAGES-1:0] done_event,
    output logic irq_n
);
    import stage_irq_pkg::*;

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    stage_vec_t stage_lower_irq_enable_ff;
    stage_vec_t stage_upper_irq_enable_ff;
    stage_vec_t stage_done_irq_enable_ff;
    stage_vec_t nxt_stage_lower_irq_enable;
    stage_vec_t nxt_stage_upper_irq_enable;
    stage_vec_t nxt_stage_done_irq_enable;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic irq_n_ff;
    logic nxt_irq_n;

    stage_flag_if lower_if();
    stage_flag_if upper_if();
    stage_flag_if done_if();

    // Only the low byte is stored; the host keeps bits 15 to 8 at zero.
    always_comb
    begin
        nxt_stage_lower_irq_enable = stage_lower_irq_enable_ff;
        nxt_stage_upper_irq_enable = stage_upper_irq_enable_ff;
        nxt_stage_done_irq_enable = stage_done_irq_enable_ff;
        if (reg_wr)
        begin
            if (reg_addr == OFS_LOWER_EN)
                nxt_stage_lower_irq_enable = reg_wdata[STAGE_MSB:0];
            else if (reg_addr == OFS_UPPER_EN)
                nxt_stage_upper_irq_enable = reg_wdata[STAGE_MSB:0];
            else if (reg_addr == OFS_DONE_EN)
                nxt_stage_done_irq_enable = reg_wdata[STAGE_MSB:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stage_lower_irq_enable_ff <= EN_RESET;
            stage_upper_irq_enable_ff <= EN_RESET;
            stage_done_irq_enable_ff <= EN_RESET;
        end
        else
        begin
            stage_lower_irq_enable_ff <= nxt_stage_lower_irq_enable;
            stage_upper_irq_enable_ff <= nxt_stage_upper_irq_enable;
            stage_done_irq_enable_ff <= nxt_stage_done_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // Flag banks
    // ------------------------------------------------------------
    // Completion has no lasting condition, so only a same-cycle completion event can block its read clear.
    assign lower_if.event_in = lower_event;
    assign lower_if.cond_hold = lower_exceeded;
    assign lower_if.read_clr = reg_rd && (reg_addr == OFS_LOWER_FLAG);
    assign lower_if.enable = stage_lower_irq_enable_ff;
    assign upper_if.event_in = upper_event;
    assign upper_if.cond_hold = upper_exceeded;
    assign upper_if.read_clr = reg_rd && (reg_addr == OFS_UPPER_FLAG);
    assign upper_if.enable = stage_upper_irq_enable_ff;
    assign done_if.event_in = done_event;
    assign done_if.cond_hold = FLAG_RESET;
    assign done_if.read_clr = reg_rd && (reg_addr == OFS_DONE_FLAG);
    assign done_if.enable = stage_done_irq_enable_ff;

    stage_flag_bank u_lower
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .port(lower_if.bank)
    );

    stage_flag_bank u_upper
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .port(upper_if.bank)
    );

    stage_flag_bank u_done
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .port(done_if.bank)
    );

    // ------------------------------------------------------------
    // Read data and interrupt output
    // ------------------------------------------------------------
    // Read data shows the value before any clear caused by this same read.
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            if (reg_addr == OFS_LOWER_EN)
                nxt_rdata = {8'h00, stage_lower_irq_enable_ff};
            else if (reg_addr == OFS_UPPER_EN)
                nxt_rdata = {8'h00, stage_upper_irq_enable_ff};
            else if (reg_addr == OFS_DONE_EN)
                nxt_rdata = {8'h00, stage_done_irq_enable_ff};
            else if (reg_addr == OFS_LOWER_FLAG)
                nxt_rdata = {8'h00, lower_if.flags};
            else if (reg_addr == OFS_UPPER_FLAG)
                nxt_rdata = {8'h00, upper_if.flags};
            else if (reg_addr == OFS_DONE_FLAG)
                nxt_rdata = {8'h00, done_if.flags};
            else
                nxt_rdata = RDATA_ZERO;
        end
        nxt_irq_n = ~(lower_if.pending | upper_if.pending | done_if.pending);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= RDATA_ZERO;
            irq_n_ff <= 1'b1;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            irq_n_ff <= nxt_irq_n;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq_n = irq_n_ff;
endmodule

// ==== stage_irq_monitor.sv ====
`timescale 1ns/100ps
// Judges the pin and the read data from the ports alone.
module stage_irq_monitor
import stage_irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0] lower_event,
    input wire logic [7:0] lower_exceeded,
    input wire logic [7:0] upper_event,
    input wire logic [7:0] upper_exceeded,
    input wire logic [7:0] done_event,
    input wire logic irq_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Only an event, a held limit or an enable write may pull the pin low.
    logic ev_hit;
    assign ev_hit = |(lower_event | lower_exceeded | upper_event | upper_exceeded | done_event);
    en_back_a: assert property (reg_wr && reg_addr inside {[OFS_LOWER_EN:OFS_DONE_EN]} ##1
        reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FF))
        else $error("enable readback wrong");
    unmapped_a: assert property (reg_rd && reg_addr > OFS_DONE_FLAG |=> reg_rdata == RDATA_ZERO)
        else $error("spare offset read not zero");
    flag_seen_a: assert property (upper_event != 8'h00 && !reg_rd ##1 !reg_rd [*2] ##1
        reg_rd && reg_addr == OFS_UPPER_FLAG |=> (reg_rdata[7:0] & $past(upper_event, 4)) == $past(upper_event, 4))
        else $error("upper event not recorded");
    flag_clear_a: assert property (reg_rd && reg_addr == OFS_UPPER_FLAG && (upper_event | upper_exceeded) == 8'h00
        ##1 (upper_event | upper_exceeded) == 8'h00 ##1 reg_rd && reg_addr == OFS_UPPER_FLAG |=> reg_rdata == 0)
        else $error("flag survived a read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    // A flag change reaches the pin two edges later; an enable write needs one more,
    // because the pending level is built from the stored enable.
    irq_fall_a: assert property ($fell(irq_n) |-> $past(ev_hit, 2) || $past(reg_wr, 3))
        else $error("interrupt asserted without a cause");
    irq_rise_a: assert property ($rose(irq_n) |-> $past(reg_rd, 2) || $past(reg_wr, 3))
        else $error("interrupt released without a cause");
    reset_idle_a: assert property ($fell(rst) |-> irq_n && reg_rdata == RDATA_ZERO)
        else $error("not idle after reset");
endmodule
bind stage_irq_ctrl stage_irq_monitor u_mon (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .lower_event, .lower_exceeded, .upper_event, .upper_exceeded, .done_event, .irq_n);

// ==== stage_irq_pkg.sv ====
package stage_irq_pkg;

    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int STAGES = 8;
    localparam logic [ADDR_W-1:0] OFS_LOWER_EN = 10'h005;
    localparam logic [ADDR_W-1:0] OFS_UPPER_EN = 10'h006;
    localparam logic [ADDR_W-1:0] OFS_DONE_EN = 10'h007;
    localparam logic [ADDR_W-1:0] OFS_LOWER_FLAG = 10'h008;
    localparam logic [ADDR_W-1:0] OFS_UPPER_FLAG = 10'h009;
    localparam logic [ADDR_W-1:0] OFS_DONE_FLAG = 10'h00A;
    localparam logic [STAGES-1:0] EN_RESET = 8'h00;
    localparam logic [STAGES-1:0] FLAG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 16'h0000;
    localparam int STAGE_MSB = 7;

    typedef logic [STAGES-1:0] stage_vec_t;

    // Source kinds, one enable register and one flag register each.
    typedef enum logic [1:0]
    {
        SRC_LOWER = 2'b00,
        SRC_UPPER = 2'b01,
        SRC_DONE = 2'b10
    } src_kind_t;

endpackage

// ==== tb_touch_stage_irq_enables.sv ====
`timescale 1ns/100ps
module tb_touch_stage_irq_enables;
    import stage_irq_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, irq_n;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, got;
    stage_vec_t lower_event, lower_exceeded, upper_event, upper_exceeded, done_event, act;
    stage_vec_t en_m [3];
    stage_vec_t flag_m [3];
    logic [31:0] seed = 32'hD424C467;
    logic [31:0] ev;
    int err_total, n_checks, j;
    stage_irq_ctrl u_dut (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .lower_event,
        .lower_exceeded, .upper_event, .upper_exceeded, .done_event, .irq_n);
    host_bus_model u_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // System clock, 8 ns period.
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Xorshift source; the fixed start makes every run alike.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
            $display("Error at %0t: got %h expected %h (mismatch %0d)", $time, g, e, ++err_total);
    endtask
    // The pin is low exactly when some recorded source is enabled.
    task automatic chk_irq();
        act = (flag_m[0] & en_m[0]) | (flag_m[1] & en_m[1]) | (flag_m[2] & en_m[2]);
        chk(16'(irq_n), 16'(act == 8'h00));
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset, then random enables, events and held limits round after round.
    initial
    begin
        rst = 1'b1;
        {lower_event, lower_exceeded, upper_event, upper_exceeded, done_event} = '0;
        err_total = 0;
        n_checks = 0;
        en_m = '{default: 8'h00};
        flag_m = '{default: 8'h00};
        cyc(8);
        rst = 1'b0;
        cyc(1);
        u_host.wr(10'h3FF, 8'hFF);
        for (int a = 5; a <= 11; a++)
        begin
            u_host.rd((a == 11) ? 10'h3FF : 10'(a), got);
            chk(got, RDATA_ZERO);
        end
        for (int it = 0; it < 40; it++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                en_m[k] = 8'(rnd());
                u_host.wr(OFS_LOWER_EN + 10'(k), en_m[k]);
                u_host.rd(OFS_LOWER_EN + 10'(k), got);
                chk(got, {8'h00, en_m[k]});
            end
            ev = rnd();
            {done_event, upper_event, lower_event} = ev[23:0];
            for (int k = 0; k < 3; k++)
                flag_m[k] |= ev[8*k +: 8];
            cyc(1);
            {done_event, upper_event, lower_event} = '0;
            cyc(2);
            chk_irq();
            // Odd rounds hold some limits, so those flags must outlive both reads.
            ev = it[0] ? rnd() : 32'h0;
            lower_exceeded = ev[7:0] & flag_m[0];
            upper_exceeded = ev[15:8] & flag_m[1];
            for (int k = 2; k < 8; k++)
            begin
                j = (k / 2) % 3;
                u_host.rd(OFS_LOWER_FLAG + 10'(j), got);
                chk(got, {8'h00, flag_m[j]});
                flag_m[j] &= (j == 0) ? lower_exceeded : (j == 1) ? upper_exceeded : 8'h00;
            end
            {lower_exceeded, upper_exceeded} = '0;
            cyc(2);
            chk_irq();
        end
        conclude();
    end
endmodule
